/* File: inc/dadc_pkg.sv */
`default_nettype none

package dadc_pkg;

  // ----------------------------------------------------------------------
  // Widths and addresses.
  // ----------------------------------------------------------------------
  localparam int          RES_WIDTH   = 10;
  localparam int          ADDR_WIDTH  = 5;
  localparam int          DATA_WIDTH  = 8;
  localparam int          NUM_MODULES = 2;
  localparam int          NUM_CHAN    = 4;
  localparam logic [4:0]  ADDR_CSR0   = 5'h10;
  localparam logic [4:0]  ADDR_CSR1   = 5'h11;
  localparam logic [4:0]  ADDR_TCR0   = 5'h12;
  localparam logic [4:0]  ADDR_TCR1   = 5'h13;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int          FLAG_BIT    = 7;
  localparam int          REQ_EN_BIT  = 6;
  localparam int          START_BIT   = 5;
  localparam int          SCAN_BIT    = 4;
  localparam int          SPEED_BIT   = 3;
  localparam int          CH_HI_BIT   = 1;
  localparam int          CH_LO_BIT   = 0;
  localparam int          TRG_EN_BIT  = 7;
  localparam int          LOW_PAD     = 6;

  // ----------------------------------------------------------------------
  // Values after reset.
  // ----------------------------------------------------------------------
  localparam logic [9:0]  RES_RESET    = 10'h000;
  localparam logic [7:0]  CSR_RESET    = 8'h00;
  localparam logic [6:0]  TCR_RESERVED = 7'h7f;
  localparam logic        TRG_RESET    = 1'b0;

  // ----------------------------------------------------------------------
  // Conversion timing; one state is one clock period.
  // ----------------------------------------------------------------------
  localparam int          CLK_NS            = 50;
  localparam int          STATE_NS          = 50;
  localparam int          CONV_LONG_STATES  = 266;
  localparam int          CONV_SHORT_STATES = 134;
  localparam int          CONV_LONG_CYC     = (CONV_LONG_STATES * STATE_NS) / CLK_NS;
  localparam int          CONV_SHORT_CYC    = (CONV_SHORT_STATES * STATE_NS) / CLK_NS;

  typedef struct packed {
    logic       end_flag;
    logic       req_en;
    logic       start;
    logic       scan;
    logic       speed;
    logic [1:0] chan;
  } dadc_ctl_t;

  typedef struct packed {
    logic       wr;
    logic [1:0] idx;
    logic [9:0] data;
  } dadc_result_t;

  typedef enum logic [1:0] {
    DADC_IDLE = 2'b01,
    DADC_CONV = 2'b10
  } dadc_state_t;

endpackage : dadc_pkg

`default_nettype wire

/* File: logic/dadc_seq.sv */
`default_nettype none

module dadc_seq (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire dadc_pkg::dadc_ctl_t  ctl,
  input  wire logic [9:0]           conv_result,
  output logic [1:0]                conv_channel,
  output dadc_pkg::dadc_result_t    result,
  output logic                      end_event,
  output logic                      single_done
);

  dadc_pkg::dadc_state_t  state;
  dadc_pkg::dadc_state_t  next_state;
  logic [8:0]             cnt;
  logic [8:0]             next_cnt;
  logic [8:0]             reload;
  logic [1:0]             next_channel;
  dadc_pkg::dadc_result_t next_result;
  logic                   next_end_event;
  logic                   next_single_done;

  // ----------------------------------------------------------------------
  // Channel sequencing.
  // ----------------------------------------------------------------------
  always_comb begin
    reload = ctl.speed ? 9'(dadc_pkg::CONV_SHORT_CYC - 1)
                       : 9'(dadc_pkg::CONV_LONG_CYC - 1);
    next_state       = state;
    next_cnt         = cnt;
    next_channel     = conv_channel;
    next_result      = '0;
    next_end_event   = 1'b0;
    next_single_done = 1'b0;
    case (state)
      dadc_pkg::DADC_IDLE: begin
        // The start bit still reads one in the cycle after a single conversion ends.
        if (ctl.start && !single_done) begin
          next_state   = dadc_pkg::DADC_CONV;
          next_cnt     = reload;
          next_channel = ctl.scan ? 2'h0 : ctl.chan;
        end
      end
      dadc_pkg::DADC_CONV: begin
        if (!ctl.start) begin
          next_state = dadc_pkg::DADC_IDLE;
        end else if (cnt != 9'h000) begin
          next_cnt = cnt - 9'h001;
        end else begin
          next_result = {1'b1, conv_channel, conv_result};
          next_cnt    = reload;
          if (!ctl.scan) begin
            next_end_event   = 1'b1;
            next_single_done = 1'b1;
            next_state       = dadc_pkg::DADC_IDLE;
          end else if (conv_channel == ctl.chan) begin
            next_end_event = 1'b1;
            next_channel   = 2'h0;
          end else begin
            next_channel = conv_channel + 2'h1;
          end
        end
      end
      default: begin
        next_state = dadc_pkg::DADC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state        <= dadc_pkg::DADC_IDLE;
      cnt          <= 9'h000;
      conv_channel <= 2'h0;
      result       <= '0;
      end_event    <= 1'b0;
      single_done  <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      conv_channel <= next_channel;
      result       <= next_result;
      end_event    <= next_end_event;
      single_done  <= next_single_done;
    end
  end

endmodule : dadc_seq

`default_nettype wire

/* File: logic/dadc_trig.sv */
`default_nettype none

module dadc_trig (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic trigger_input_pin_n,
  input  wire logic timer_trigger,
  input  wire logic trigger_enable,
  output logic      trigger_pulse
);

  logic [2:0] sync;
  logic [2:0] next_sync;
  logic       level;
  logic       next_level;
  logic       next_pulse;

  // ----------------------------------------------------------------------
  // Pin filter and falling edge.
  // ----------------------------------------------------------------------
  // The pin is taken as settled only when the second and third stages agree.
  always_comb begin
    next_sync  = {sync[1:0], trigger_input_pin_n};
    next_level = (sync[1] == sync[2]) ? sync[2] : level;
    next_pulse = trigger_enable & ((level & ~next_level) | timer_trigger);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync          <= 3'h7;
      level         <= 1'b1;
      trigger_pulse <= 1'b0;
    end else begin
      sync          <= next_sync;
      level         <= next_level;
      trigger_pulse <= next_pulse;
    end
  end

endmodule : dadc_trig

`default_nettype wire

/* File: logic/dadc_top.sv */
`default_nettype none

module dadc_top (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             standby,
  input  wire logic [4:0]       bus_addr,
  input  wire logic             bus_rd,
  input  wire logic             bus_wr,
  input  wire logic [7:0]       bus_wdata,
  output logic      [7:0]       bus_rdata,
  input  wire logic [1:0]       xfer_active,
  input  wire logic             trigger_input_pin_n,
  input  wire logic             timer_trigger,
  input  wire logic [1:0][9:0]  conv_result,
  output logic      [1:0][1:0]  conv_channel,
  output logic      [1:0]       conv_done_request
);

  // ----------------------------------------------------------------------
  // Decoding helpers.
  // ----------------------------------------------------------------------
  function automatic logic mod_of(input logic [4:0] addr);
    mod_of = addr[4] ? addr[0] : addr[3];
  endfunction : mod_of

  function automatic logic [7:0] csr_image(input dadc_pkg::dadc_ctl_t c);
    csr_image = {c.end_flag, c.req_en, c.start, c.scan, c.speed, 1'b0, c.chan};
  endfunction : csr_image

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic                   clr;
  logic [9:0]             res [8];
  logic [9:0]             next_res [8];
  logic [1:0]             temp;
  logic [1:0]             next_temp;
  dadc_pkg::dadc_ctl_t    ctl [2];
  dadc_pkg::dadc_ctl_t    next_ctl [2];
  logic [1:0]             trg_en;
  logic [1:0]             next_trg_en;
  logic [1:0]             armed;
  logic [1:0]             next_armed;
  logic [7:0]             next_rdata;
  logic [1:0]             next_req;
  logic                   trig_pulse;
  dadc_pkg::dadc_result_t result [2];
  logic [1:0]             end_event;
  logic [1:0]             single_done;
  logic                   sel;

  // Standby acts exactly like power-on reset; manual reset has no input here,
  // so nothing in this block is disturbed by it.
  assign clr = reset | standby;

  // ----------------------------------------------------------------------
  // Converter sequencers, one per module.
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < dadc_pkg::NUM_MODULES; g++) begin : g_mod
    dadc_seq dadc_seq_i (
      .sys_clk      (sys_clk),
      .reset        (clr),
      .ctl          (ctl[g]),
      .conv_result  (conv_result[g]),
      .conv_channel (conv_channel[g]),
      .result       (result[g]),
      .end_event    (end_event[g]),
      .single_done  (single_done[g])
    );
  end

  dadc_trig dadc_trig_i (
    .sys_clk             (sys_clk),
    .reset               (clr),
    .trigger_input_pin_n (trigger_input_pin_n),
    .timer_trigger       (timer_trigger),
    .trigger_enable      (trg_en[0] | trg_en[1]),
    .trigger_pulse       (trig_pulse)
  );

  // ----------------------------------------------------------------------
  // Register access and control.
  // ----------------------------------------------------------------------
  always_comb begin
    sel         = bus_addr[0];
    next_res    = res;
    next_temp   = temp;
    next_ctl    = ctl;
    next_trg_en = trg_en;
    next_armed  = armed;
    next_rdata  = 8'h00;
    next_req    = 2'h0;
    if (bus_rd) begin
      if (!bus_addr[4]) begin
        if (!bus_addr[0]) begin
          next_rdata = res[bus_addr[3:1]][9:2];
          next_temp  = res[bus_addr[3:1]][1:0];
        end else begin
          next_rdata = {temp, 6'h00};
        end
      end else begin
        case (bus_addr)
          dadc_pkg::ADDR_CSR0, dadc_pkg::ADDR_CSR1: begin
            next_rdata = csr_image(ctl[sel]);
            if (ctl[sel].end_flag) begin
              next_armed[sel] = 1'b1;
            end
          end
          dadc_pkg::ADDR_TCR0, dadc_pkg::ADDR_TCR1: begin
            next_rdata = {trg_en[sel], dadc_pkg::TCR_RESERVED};
          end
          default: begin
            next_rdata = 8'h00;
          end
        endcase
      end
    end
    if (bus_wr) begin
      case (bus_addr)
        dadc_pkg::ADDR_CSR0, dadc_pkg::ADDR_CSR1: begin
          next_ctl[sel].req_en = bus_wdata[dadc_pkg::REQ_EN_BIT];
          next_ctl[sel].start  = bus_wdata[dadc_pkg::START_BIT];
          next_ctl[sel].scan   = bus_wdata[dadc_pkg::SCAN_BIT];
          next_ctl[sel].speed  = bus_wdata[dadc_pkg::SPEED_BIT];
          next_ctl[sel].chan   = bus_wdata[dadc_pkg::CH_HI_BIT:dadc_pkg::CH_LO_BIT];
          if (!bus_wdata[dadc_pkg::FLAG_BIT] && armed[sel]) begin
            next_ctl[sel].end_flag = 1'b0;
          end
          next_armed[sel] = 1'b0;
        end
        dadc_pkg::ADDR_TCR0, dadc_pkg::ADDR_TCR1: begin
          next_trg_en[sel] = bus_wdata[dadc_pkg::TRG_EN_BIT];
        end
        default: begin
          next_trg_en = trg_en;
        end
      endcase
    end
    for (int m = 0; m < dadc_pkg::NUM_MODULES; m++) begin
      if (xfer_active[m] && (bus_rd || bus_wr) && (mod_of(bus_addr) == 1'(m))) begin
        next_ctl[m].end_flag = 1'b0;
      end
      if (result[m].wr) begin
        next_res[m * dadc_pkg::NUM_CHAN + int'(result[m].idx)] = result[m].data;
      end
      if (trig_pulse) begin
        next_ctl[m].start = 1'b1;
      end
      if (single_done[m]) begin
        next_ctl[m].start = 1'b0;
      end
      // A completion in the same cycle as a clear must not be lost.
      if (end_event[m]) begin
        next_ctl[m].end_flag = 1'b1;
      end
      next_req[m] = next_ctl[m].end_flag & next_ctl[m].req_en;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clr) begin
      for (int i = 0; i < 8; i++) begin
        res[i] <= dadc_pkg::RES_RESET;
      end
      for (int m = 0; m < dadc_pkg::NUM_MODULES; m++) begin
        ctl[m] <= {dadc_pkg::CSR_RESET[7:3], dadc_pkg::CSR_RESET[1:0]};
      end
      temp              <= 2'h0;
      trg_en            <= {2{dadc_pkg::TRG_RESET}};
      armed             <= 2'h0;
      bus_rdata         <= 8'h00;
      conv_done_request <= 2'h0;
    end else begin
      res               <= next_res;
      ctl               <= next_ctl;
      temp              <= next_temp;
      trg_en            <= next_trg_en;
      armed             <= next_armed;
      bus_rdata         <= next_rdata;
      conv_done_request <= next_req;
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  low_byte_pad_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_rd && !bus_addr[4] && bus_addr[0]) |=> (bus_rdata[5:0] == 6'h00))
    else $error("result lower byte has nonzero pad bits");

  temp_latch_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_rd && !bus_addr[4] && !bus_addr[0]) ##1 !bus_rd
      ##1 (bus_rd && !bus_addr[4] && bus_addr[0])
      |=> (bus_rdata[7:6] == $past(res[bus_addr[3:1]][1:0], 3)))
    else $error("lower byte read did not return latched bits");

  reset_clear_a: assert property (
    @(posedge sys_clk)
    clr |=> (res[0] == 10'h000 && res[7] == 10'h000 && ctl[0] == '0 && trg_en == 2'h0))
    else $error("reset or standby did not clear registers");

  csr_bit2_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_rd && (bus_addr == dadc_pkg::ADDR_CSR0)) |=> !bus_rdata[2])
    else $error("control status bit 2 read as one");

  tcr_ones_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_rd && (bus_addr == dadc_pkg::ADDR_TCR1)) |=> (bus_rdata[6:0] == 7'h7f))
    else $error("trigger register reserved bits not ones");

  request_gate_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (!ctl[0].req_en && !(bus_wr && bus_addr == dadc_pkg::ADDR_CSR0))
      |=> !conv_done_request[0])
    else $error("done request issued while disabled");

  flag_set_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    end_event[1] |=> (ctl[1].end_flag && (conv_done_request[1] == ctl[1].req_en)))
    else $error("end flag not set on completion");

  no_write_set_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_wr && bus_addr == dadc_pkg::ADDR_CSR0 && !ctl[0].end_flag && !end_event[0])
      |=> !ctl[0].end_flag)
    else $error("end flag set by a software write");

  single_stop_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (single_done[0] && !trig_pulse) |=> !ctl[0].start)
    else $error("start bit not cleared after single conversion");

  trigger_start_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (trig_pulse && !single_done[0] && !single_done[1])
      |=> (ctl[0].start && ctl[1].start))
    else $error("trigger did not set both start bits");

  xfer_clear_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (xfer_active[0] && bus_rd && bus_addr == dadc_pkg::ADDR_CSR0 && !end_event[0])
      |=> !ctl[0].end_flag)
    else $error("transfer access left end flag set");

  csr1_bit2_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_rd && (bus_addr == dadc_pkg::ADDR_CSR1)) |=> !bus_rdata[2])
    else $error("control status 1 bit 2 read as one");

  tcr0_ones_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_rd && (bus_addr == dadc_pkg::ADDR_TCR0)) |=> (bus_rdata[6:0] == 7'h7f))
    else $error("trigger register 0 reserved bits not ones");

  upper_byte_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_rd && !bus_addr[4] && !bus_addr[0]) |=> (bus_rdata == $past(res[bus_addr[3:1]][9:2])))
    else $error("result upper byte read wrong bits");

  temp_capture_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_rd && !bus_addr[4] && !bus_addr[0]) |=> (temp == $past(res[bus_addr[3:1]][1:0])))
    else $error("upper byte read did not latch lower bits");

  request_follow_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    conv_done_request == {ctl[1].end_flag & ctl[1].req_en, ctl[0].end_flag & ctl[0].req_en})
    else $error("done request differs from flag and enable");

  flag_set0_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    end_event[0] |=> ctl[0].end_flag)
    else $error("module 0 end flag not set on completion");

  scan_hold_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (ctl[0].scan && ctl[0].start && !single_done[0]
      && !(bus_wr && bus_addr == dadc_pkg::ADDR_CSR0)) |=> ctl[0].start)
    else $error("scan start bit dropped without software");

  scan_range_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (result[0].wr && ctl[0].scan) |-> (result[0].idx <= ctl[0].chan))
    else $error("scan converted a channel outside the selection");

  single_chan_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (result[1].wr && !ctl[1].scan) |-> (result[1].idx == ctl[1].chan))
    else $error("single conversion stored the wrong channel");

  store_mod0_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    result[0].wr |=> (res[{1'b0, $past(result[0].idx)}] == $past(result[0].data)))
    else $error("module 0 result stored in the wrong register");

  store_mod1_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    result[1].wr |=> (res[{1'b1, $past(result[1].idx)}] == $past(result[1].data)))
    else $error("module 1 result stored in the wrong register");

  trig_enabled_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    trig_pulse |-> ($past(trg_en) != 2'h0))
    else $error("trigger accepted while disabled");

  start_write_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (bus_wr && bus_addr == dadc_pkg::ADDR_CSR1 && bus_wdata[dadc_pkg::START_BIT]
      && !single_done[1]) |=> ctl[1].start)
    else $error("start bit write did not take");

  flag_keep_a: assert property (
    @(posedge sys_clk) disable iff (clr)
    (ctl[1].end_flag && !bus_wr && !xfer_active[1]) |=> ctl[1].end_flag)
    else $error("end flag dropped without a clearing access");

endmodule : dadc_top

`default_nettype wire

/* File: sim/dadc_core_model.sv */
`default_nettype none

module dadc_core_model (
  input  wire logic [1:0][1:0] conv_channel,
  output logic      [1:0][9:0] conv_result
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // Converter core answers.
  // ----------------------------------------------------------------------
  // Each code names its module and channel, so a result that lands in the wrong
  // register cannot pass for the right one.
  always_comb begin
    conv_result[0] = {1'b0, conv_channel[0], 7'h5b};
    conv_result[1] = {1'b1, conv_channel[1], 7'h5b};
  end
endmodule : dadc_core_model

`default_nettype wire

/* File: sim/dadc_top_bench.sv */
`default_nettype none

`define CHECK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("FAIL %s exp %h got %h", what, exp, got); \
    end \
  end

module dadc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic            sys_clk;
  logic            reset;
  logic            standby;
  logic [4:0]      bus_addr;
  logic            bus_rd;
  logic            bus_wr;
  logic [7:0]      bus_wdata;
  logic [7:0]      bus_rdata;
  logic [1:0]      xfer_active;
  logic            trigger_input_pin_n;
  logic            timer_trigger;
  logic [1:0][9:0] conv_result;
  logic [1:0][1:0] conv_channel;
  logic [1:0]      conv_done_request;
  logic [7:0]      rd;
  int              fails;
  int              n_checks;
  int              cyc;

  dadc_top dadc_top_i (
    .sys_clk             (sys_clk),
    .reset               (reset),
    .standby             (standby),
    .bus_addr            (bus_addr),
    .bus_rd              (bus_rd),
    .bus_wr              (bus_wr),
    .bus_wdata           (bus_wdata),
    .bus_rdata           (bus_rdata),
    .xfer_active         (xfer_active),
    .trigger_input_pin_n (trigger_input_pin_n),
    .timer_trigger       (timer_trigger),
    .conv_result         (conv_result),
    .conv_channel        (conv_channel),
    .conv_done_request   (conv_done_request)
  );

  dadc_core_model dadc_core_model_i (
    .conv_channel (conv_channel),
    .conv_result  (conv_result)
  );

  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------------
  // Bus tasks.
  // ----------------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask : wr

  // Read data is sampled mid-cycle, away from the edge that retires it.
  task automatic rdb(input logic [4:0] a);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    @(negedge sys_clk);
    rd = bus_rdata;
  endtask : rdb

  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string what);
    rdb(a);
    `CHECK(what, e, rd)
  endtask : rdc

  function automatic logic [9:0] res(input logic m, input logic [1:0] c);
    return {m, c, 7'h5b};
  endfunction : res

  task automatic rres(input logic m, input logic [1:0] c, input logic [9:0] e);
    rdc({1'b0, m, c, 1'b0}, e[9:2], "result upper");
    rdc({1'b0, m, c, 1'b1}, {e[1:0], 6'h00}, "result lower");
  endtask : rres

  // Polling reads take two cycles, so the window is widened by that much.
  task automatic wflag(input logic [4:0] a, input int lo, input int hi);
    cyc = 0;
    rd  = 8'h00;
    while (rd[7] !== 1'b1 && cyc < 2000) begin
      rdb(a);
      cyc += 2;
    end
    `CHECK("end flag delay", 1'b1, (cyc >= lo && cyc <= hi))
  endtask : wflag

  task automatic trig(input logic pin, input logic tmr);
    @(posedge sys_clk);
    trigger_input_pin_n <= ~pin;
    timer_trigger       <= tmr;
    @(posedge sys_clk);
    timer_trigger <= 1'b0;
    repeat (6) @(posedge sys_clk);
    trigger_input_pin_n <= 1'b1;
  endtask : trig

  task automatic test_done();
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // Watchdog.
  // ----------------------------------------------------------------------
  initial begin
    repeat (10000) @(posedge sys_clk);
    fails++;
    test_done();
  end

  // ----------------------------------------------------------------------
  // Tests.
  // ----------------------------------------------------------------------
  initial begin
    sys_clk             = 1'b0;
    reset               = 1'b1;
    standby             = 1'b0;
    bus_addr            = 5'h00;
    bus_rd              = 1'b0;
    bus_wr              = 1'b0;
    bus_wdata           = 8'h00;
    xfer_active         = 2'b00;
    trigger_input_pin_n = 1'b1;
    timer_trigger       = 1'b0;
    fails               = 0;
    n_checks            = 0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rdc(a[4:0], 8'h00, "result reset");
    end
    rdc(5'h10, 8'h00, "csr0 reset");
    rdc(5'h11, 8'h00, "csr1 reset");
    rdc(5'h12, 8'h7f, "trig ctl0 reset");
    rdc(5'h13, 8'h7f, "trig ctl1 reset");
    wr(5'h10, 8'h9c);
    rdc(5'h10, 8'h18, "csr0 write mask");
    wr(5'h12, 8'h00);
    rdc(5'h12, 8'h7f, "trig ctl reserved");
    wr(5'h12, 8'h80);
    rdc(5'h12, 8'hff, "trig ctl enable");
    wr(5'h12, 8'h7f);
    // Single conversion, module 0, channel 1, request enabled.
    wr(5'h10, 8'h61);
    wflag(5'h10, 262, 280);
    `CHECK("request 0 set", 1'b1, conv_done_request[0])
    rres(1'b0, 2'd1, res(1'b0, 2'd1));
    rdc(5'h10, 8'hc1, "single done 0");
    wr(5'h10, 8'hc1);
    wr(5'h10, 8'h41);
    rdc(5'h10, 8'hc1, "clear unarmed");
    wr(5'h10, 8'h41);
    rdc(5'h10, 8'h41, "clear armed");
    `CHECK("request 0 clear", 1'b0, conv_done_request[0])
    // Fast conversion, module 1, channel 3, request masked.
    wr(5'h11, 8'h2b);
    wflag(5'h11, 128, 148);
    `CHECK("request masked", 1'b0, conv_done_request[1])
    rdc(5'h11, 8'h8b, "single done 1");
    wr(5'h11, 8'hcb);
    rdc(5'h11, 8'hcb, "flag kept");
    `CHECK("request 1 set", 1'b1, conv_done_request[1])
    @(posedge sys_clk);
    xfer_active <= 2'b10;
    rres(1'b1, 2'd3, res(1'b1, 2'd3));
    @(posedge sys_clk);
    xfer_active <= 2'b00;
    rdc(5'h11, 8'h4b, "transfer clear");
    // Scan over the first three channels of module 0.
    wr(5'h10, 8'h72);
    repeat (4) @(posedge sys_clk);
    `CHECK("scan first channel", 2'd0, conv_channel[0])
    wflag(5'h10, 795, 830);
    rdc(5'h10, 8'hf2, "scan running");
    wr(5'h10, 8'h52);
    rdc(5'h10, 8'h52, "scan stopped");
    for (int c = 0; c < 3; c++) begin
      rres(1'b0, c[1:0], res(1'b0, c[1:0]));
    end
    rres(1'b0, 2'd3, 10'h000);
    // Triggers: ignored while disabled, shared and ORed when enabled.
    wr(5'h10, 8'h03);
    trig(1'b1, 1'b1);
    rdc(5'h10, 8'h03, "trigger ignored");
    wr(5'h13, 8'h80);
    trig(1'b1, 1'b0);
    rdc(5'h10, 8'h23, "pin start 0");
    rdb(5'h11);
    `CHECK("pin start 1", 1'b1, rd[5])
    repeat (300) @(posedge sys_clk);
    rres(1'b0, 2'd3, res(1'b0, 2'd3));
    wr(5'h13, 8'h00);
    rdc(5'h13, 8'h7f, "trig ctl1 off");
    wr(5'h12, 8'h80);
    trig(1'b0, 1'b1);
    rdb(5'h11);
    `CHECK("timer start 1", 1'b1, rd[5])
    repeat (300) @(posedge sys_clk);
    // Transfer controller access on module 0 clears its end flag.
    xfer_active <= 2'b01;
    rdb(5'h10);
    `CHECK("flag before transfer", 8'h83, rd)
    @(posedge sys_clk);
    xfer_active <= 2'b00;
    rdc(5'h10, 8'h03, "transfer clear 0");
    // Standby clears everything, including stored results.
    @(posedge sys_clk);
    standby <= 1'b1;
    @(posedge sys_clk);
    standby <= 1'b0;
    rres(1'b0, 2'd3, 10'h000);
    rdc(5'h10, 8'h00, "standby csr0");
    rdc(5'h12, 8'h7f, "standby trig ctl0");
    rdc(5'h14, 8'h00, "unmapped read");
    test_done();
  end
endmodule : dadc_top_bench

`undef CHECK

`default_nettype wire
